// file: apb_host_model.sv
module apb_host_model (
	// clock
	input wire logic clk,
	// apb master side
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end
	// held until ready is seen; released data is scrambled, not kept
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d;
		@(posedge clk);
	endtask : xfer
endmodule : apb_host_model

// file: fp_log_instruction_unit.sv
// Functional notes
// - operand-mode bit 0 is register to register, 1 is operand to register.
// - in operand mode the source specifier is the source data format.
// - in register mode the source specifier names the source fp register.
// - result goes to destination register; equal fields read then overwrite.
// - address mode field decoded in operand mode only; address register direct is refused there.
// - data register direct only for byte, word, long or single formats.
// - three-bit identifier picks the coprocessor; respond to own id only.
// - base-two log converts source, computes log, stores in destination.
// - natural log converts source, computes ln, stores in destination.
// - negative gives NaN, zero gives minus inf, plus inf gives plus inf.
// - operand error flag set when source below zero, else cleared.
// - divide-by-zero flag set when source is zero, else cleared.
// - unordered, overflow and underflow flags always cleared.
// - quotient byte of the status register left unchanged.
// - decimal input inexact follows packed rules, cleared for others.
// - accrued byte gathers current exception flags after each operation.
module fp_log_instruction_unit (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);

	typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_EXEC} state_t;

	// integer or fixed point magnitude to single precision, truncating
	function automatic logic [31:0] to_single(input logic neg,
		input logic [31:0] mag, input logic [7:0] bias);
		logic [31:0] norm;
		logic [4:0] msb;
		msb = 5'h0;
		for (int i = 0; i < 32; i++) begin
			if (mag[i]) begin
				msb = 5'(i);
			end
		end
		norm = mag << (5'h1F - msb);
		if (mag == 32'h0) begin
			to_single = 32'h0;
		end else begin
			to_single = {neg, 8'({3'h0, msb} + bias), norm[30:8]};
		end
	endfunction : to_single

	state_t state_reg, state_next;
	logic [2:0] own_id_reg, own_id_next;
	logic packed_inex_reg, packed_inex_next;
	logic [15:0] first_reg, first_next;
	logic [15:0] cmd_reg, cmd_next;
	logic [31:0] ea_data_reg, ea_data_next;
	logic [31:0] fpsr_reg, fpsr_next;
	logic [31:0] src_reg, src_next;
	logic [2:0] reject_reg, reject_next;
	logic done_reg, done_next;
	logic [31:0] fp_reg [8];
	logic [31:0] fp_next [8];
	logic [31:0] prdata_reg, prdata_next;
	logic pready_reg, pready_next;
	logic pslverr_reg, pslverr_next;

	logic setup, wr_en, is_fpreg, mapped;
	logic [31:0] rd_mux;
	logic rm;
	logic [2:0] spec, dst, ea_mode, ea_reg;
	logic [6:0] opmode;
	fp_log_pkg::reject_t reject;
	logic [31:0] conv;
	logic s_neg, s_nan, s_inf, s_zero;
	logic [32:0] fx;
	logic [31:0] mag;
	logic [47:0] ln_prod;
	logic [31:0] result;
	logic [7:0] exc, acc;
	localparam int FPSR_TOP = fp_log_pkg::FPSR_EXC_LSB + 8;

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;

	// field split shared by decode and execute
	assign rm = cmd_reg[14];
	assign spec = cmd_reg[12:10];
	assign dst = cmd_reg[9:7];
	assign opmode = cmd_reg[6:0];
	assign ea_mode = first_reg[5:3];
	assign ea_reg = first_reg[2:0];

	// decode check; first failure found is reported
	always_comb begin
		reject = fp_log_pkg::REJ_NONE;
		if (first_reg[15:12] != fp_log_pkg::LINE_HEADER ||
			first_reg[8:6] != 3'h0) begin
			reject = fp_log_pkg::REJ_HEADER;
		end else if (first_reg[11:9] != own_id_reg) begin
			reject = fp_log_pkg::REJ_NOT_OWN;
		end else if (cmd_reg[15] || cmd_reg[13]) begin
			reject = fp_log_pkg::REJ_COMMAND;
		end else if (opmode != fp_log_pkg::OPMODE_LOG2 &&
			opmode != fp_log_pkg::OPMODE_LN) begin
			reject = fp_log_pkg::REJ_OPMODE;
		// address field only checked in operand mode
		end else if (rm) begin
			if (spec == fp_log_pkg::FMT_ILLEGAL) begin
				reject = fp_log_pkg::REJ_FORMAT;
			end else if (ea_mode == fp_log_pkg::EA_ADDR_DIRECT ||
				(ea_mode == fp_log_pkg::EA_SPECIAL &&
				ea_reg > fp_log_pkg::EA_SPECIAL_MAX)) begin
				reject = fp_log_pkg::REJ_EA;
			end else if (ea_mode == fp_log_pkg::EA_DATA_DIRECT &&
				spec != fp_log_pkg::FMT_BYTE &&
				spec != fp_log_pkg::FMT_WORD &&
				spec != fp_log_pkg::FMT_LONG &&
				spec != fp_log_pkg::FMT_SINGLE) begin
				reject = fp_log_pkg::REJ_EA;
			end
		end
	end

	// source conversion; wide real formats arrive already narrowed
	always_comb begin
		conv = ea_data_reg;
		unique case (spec)
			fp_log_pkg::FMT_LONG:
				conv = to_single(ea_data_reg[31], ea_data_reg[31] ?
					32'(-ea_data_reg) : ea_data_reg, fp_log_pkg::EXP_BIAS);
			fp_log_pkg::FMT_WORD:
				conv = to_single(ea_data_reg[15], ea_data_reg[15] ?
					32'(-{{16{1'b1}}, ea_data_reg[15:0]}) :
					{16'h0, ea_data_reg[15:0]}, fp_log_pkg::EXP_BIAS);
			fp_log_pkg::FMT_BYTE:
				conv = to_single(ea_data_reg[7], ea_data_reg[7] ?
					32'(-{{24{1'b1}}, ea_data_reg[7:0]}) :
					{24'h0, ea_data_reg[7:0]}, fp_log_pkg::EXP_BIAS);
			default:
				conv = ea_data_reg;
		endcase
	end

	// log datapath; linear mantissa estimate trades accuracy for area
	always_comb begin
		s_neg = src_reg[31];
		s_nan = src_reg[30:23] == fp_log_pkg::EXP_MAX && src_reg[22:0] != 0;
		s_inf = src_reg[30:23] == fp_log_pkg::EXP_MAX && src_reg[22:0] == 0;
		// subnormals flush to zero
		s_zero = src_reg[30:23] == 8'h00;
		fx = {2'h0, src_reg[30:0]} - {2'h0, fp_log_pkg::EXP_BIAS, 23'h0};
		mag = fx[32] ? 32'(-fx) : fx[31:0];
		ln_prod = mag * fp_log_pkg::LN2_Q16;
		exc = 8'h00;
		result = to_single(fx[32], mag, fp_log_pkg::FRAC_BIAS);
		exc[fp_log_pkg::EXC_RESULT_INEXACT_FLAG] = src_reg[22:0] != 0;
		if (opmode == fp_log_pkg::OPMODE_LN) begin
			result = to_single(fx[32], ln_prod[47:16], fp_log_pkg::FRAC_BIAS);
			exc[fp_log_pkg::EXC_RESULT_INEXACT_FLAG] = fx != 0;
		end
		if (s_nan) begin
			result = src_reg | fp_log_pkg::QUIET_BIT;
			exc[fp_log_pkg::EXC_SIGNALLING_NAN_FLAG] = !src_reg[22];
			exc[fp_log_pkg::EXC_RESULT_INEXACT_FLAG] = 1'b0;
		end else if (s_zero) begin
			result = fp_log_pkg::NEG_INF;
			exc[fp_log_pkg::EXC_DZ] = 1'b1;
			exc[fp_log_pkg::EXC_RESULT_INEXACT_FLAG] = 1'b0;
		end else if (s_neg) begin
			result = fp_log_pkg::QUIET_NAN;
			exc[fp_log_pkg::EXC_OPERAND_ERROR_FLAG] = 1'b1;
			exc[fp_log_pkg::EXC_RESULT_INEXACT_FLAG] = 1'b0;
		end else if (s_inf) begin
			result = fp_log_pkg::POS_INF;
			exc[fp_log_pkg::EXC_RESULT_INEXACT_FLAG] = 1'b0;
		end
		// unordered, overflow, underflow stay zero from above
		exc[fp_log_pkg::EXC_BRANCH_UNORDERED_FLAG] = 1'b0;
		exc[fp_log_pkg::EXC_DECIMAL_INPUT_INEXACT_FLAG] = rm && spec == fp_log_pkg::FMT_PACKED &&
			packed_inex_reg;
		acc = fpsr_reg[7:0];
		acc[7] = acc[7] | exc[fp_log_pkg::EXC_BRANCH_UNORDERED_FLAG] |
			exc[fp_log_pkg::EXC_SIGNALLING_NAN_FLAG] | exc[fp_log_pkg::EXC_OPERAND_ERROR_FLAG];
		acc[6] = acc[6] | exc[fp_log_pkg::EXC_OVERFLOW_FLAG];
		acc[5] = acc[5] | (exc[fp_log_pkg::EXC_UNDERFLOW_FLAG] &
			exc[fp_log_pkg::EXC_RESULT_INEXACT_FLAG]);
		acc[4] = acc[4] | exc[fp_log_pkg::EXC_DZ];
		acc[3] = acc[3] | exc[fp_log_pkg::EXC_RESULT_INEXACT_FLAG] |
			exc[fp_log_pkg::EXC_DECIMAL_INPUT_INEXACT_FLAG] | exc[fp_log_pkg::EXC_OVERFLOW_FLAG];
	end

	// apb decode and read mux
	always_comb begin
		setup = psel && !penable;
		wr_en = psel && penable && pready_reg && pwrite && !pslverr_reg;
		is_fpreg = paddr[7:5] == fp_log_pkg::ADDR_FPREG_HI &&
			paddr[1:0] == 2'h0;
		mapped = 1'b1;
		rd_mux = 32'h0;
		if (is_fpreg) begin
			rd_mux = fp_reg[paddr[4:2]];
		end else begin
			unique case (paddr)
				fp_log_pkg::ADDR_CTRL: begin
					rd_mux[fp_log_pkg::CTRL_ID_LSB +: 3] = own_id_reg;
					rd_mux[fp_log_pkg::CTRL_PACKED_INEX] = packed_inex_reg;
				end
				fp_log_pkg::ADDR_OPWORD: rd_mux = {first_reg, cmd_reg};
				fp_log_pkg::ADDR_EA_DATA: rd_mux = ea_data_reg;
				fp_log_pkg::ADDR_FPSR: rd_mux = fpsr_reg;
				fp_log_pkg::ADDR_STATUS: begin
					rd_mux[fp_log_pkg::STAT_BUSY] = state_reg != ST_IDLE;
					rd_mux[fp_log_pkg::STAT_DONE] = done_reg;
					rd_mux[fp_log_pkg::STAT_REJECT_LSB +: 3] = reject_reg;
				end
				default: mapped = 1'b0;
			endcase
		end
		pready_next = setup;
		pslverr_next = setup && !mapped;
		prdata_next = (setup && !pwrite && mapped) ? rd_mux : 32'h0;
	end

	// register and sequencer next values
	always_comb begin
		state_next = state_reg;
		own_id_next = own_id_reg;
		packed_inex_next = packed_inex_reg;
		first_next = first_reg;
		cmd_next = cmd_reg;
		ea_data_next = ea_data_reg;
		fpsr_next = fpsr_reg;
		src_next = src_reg;
		reject_next = reject_reg;
		done_next = done_reg;
		fp_next = fp_reg;
		if (wr_en) begin
			if (is_fpreg) begin
				fp_next[paddr[4:2]] = pwdata;
			end
			unique case (paddr)
				fp_log_pkg::ADDR_CTRL: begin
					own_id_next = pwdata[fp_log_pkg::CTRL_ID_LSB +: 3];
					packed_inex_next = pwdata[fp_log_pkg::CTRL_PACKED_INEX];
				end
				fp_log_pkg::ADDR_OPWORD: begin
					// a new operation is only taken while idle
					if (state_reg == ST_IDLE) begin
						first_next = pwdata[31:16];
						cmd_next = pwdata[15:0];
						done_next = 1'b0;
						reject_next = fp_log_pkg::REJ_NONE;
						state_next = ST_FETCH;
					end
				end
				fp_log_pkg::ADDR_EA_DATA: ea_data_next = pwdata;
				fp_log_pkg::ADDR_FPSR: fpsr_next = pwdata;
				default: begin
				end
			endcase
		end
		unique case (state_reg)
			ST_IDLE: begin
			end
			ST_FETCH: begin
				reject_next = reject;
				src_next = rm ? conv : fp_reg[spec];
				done_next = reject != fp_log_pkg::REJ_NONE;
				state_next = done_next ? ST_IDLE : ST_EXEC;
			end
			ST_EXEC: begin
				fp_next[dst] = result;
				fpsr_next = {fpsr_reg[31:FPSR_TOP], exc, acc};
				done_next = 1'b1;
				state_next = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			state_reg <= ST_IDLE;
			own_id_reg <= fp_log_pkg::OWN_ID_RESET;
			packed_inex_reg <= 1'b0;
			first_reg <= 16'h0000;
			cmd_reg <= 16'h0000;
			ea_data_reg <= 32'h00000000;
			fpsr_reg <= 32'h00000000;
			src_reg <= 32'h00000000;
			reject_reg <= fp_log_pkg::REJ_NONE;
			done_reg <= 1'b0;
			for (int i = 0; i < 8; i++) begin
				fp_reg[i] <= 32'h00000000;
			end
			prdata_reg <= 32'h00000000;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			own_id_reg <= own_id_next;
			packed_inex_reg <= packed_inex_next;
			first_reg <= first_next;
			cmd_reg <= cmd_next;
			ea_data_reg <= ea_data_next;
			fpsr_reg <= fpsr_next;
			src_reg <= src_next;
			reject_reg <= reject_next;
			done_reg <= done_next;
			fp_reg <= fp_next;
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
		end
	end

endmodule : fp_log_instruction_unit

// file: fp_log_instruction_unit_properties.sv
module fp_log_checker (
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// apb bus as seen at the block
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	timeunit 1ns;
	timeprecision 1ps;
	logic setup, fin, rdf, stf, unm;
	logic [7:0] quot_reg, quot_next;
	logic op_reg, op_next;
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	always_comb begin
		setup = psel && !penable;
		fin = psel && penable && pready;
		rdf = fin && !pwrite && paddr == fp_log_pkg::ADDR_FPSR;
		stf = fin && !pwrite && paddr == fp_log_pkg::ADDR_STATUS;
		unm = paddr[1:0] != 2'h0 || paddr > 8'h3C;
		unm = unm || (paddr > 8'h10 && paddr < 8'h20);
		quot_next = quot_reg;
		op_next = op_reg;
		// a software write re-seeds both; a clean finish arms the flag check
		if (fin && pwrite && paddr == fp_log_pkg::ADDR_FPSR) begin
			quot_next = pwdata[23:16];
			op_next = 1'b0;
		end else if (stf && prdata[1:0] == 2'h2 && prdata[6:4] == 3'h0) begin
			op_next = 1'b1;
		end
	end
	always_ff @(posedge clk) begin
		if (reset) begin
			quot_reg <= 8'h00;
			op_reg <= 1'b0;
		end else begin
			quot_reg <= quot_next;
			op_reg <= op_next;
		end
	end
	ready_after_setup_a: assert property (setup |=> pready)
		else $error("no ready in access cycle");
	ready_single_a: assert property (pready |=> !pready)
		else $error("ready held too long");
	err_map_a: assert property (setup |=> pslverr == $past(unm))
		else $error("error flag does not follow address map");
	idle_zero_a: assert property (!pready |-> prdata == 32'h0)
		else $error("read data not zero outside access");
	quot_kept_a: assert property (
		rdf |-> prdata[23:16] == quot_reg) else $error("quotient byte moved");
	exc_cleared_a: assert property (
		rdf && op_reg |-> prdata[15] == 1'b0 && prdata[12:11] == 2'h0)
		else $error("stale exception flags");
	dz_accrued_a: assert property (
		rdf && op_reg && prdata[10] |-> prdata[4])
		else $error("divide flag not accrued");
	operand_error_flag_accrued_a: assert property (
		rdf && op_reg && prdata[13] |-> prdata[7])
		else $error("operand error not accrued");
	reject_done_a: assert property (
		stf && prdata[6:4] != 3'h0 |-> prdata[1:0] == 2'h2)
		else $error("refused op not reported done");
	cover property (stf && prdata[1] && prdata[6:4] == 3'h0);
	cover property (stf && prdata[6:4] == 3'h2);
	cover property (fin && pslverr);
endmodule : fp_log_checker

// file: fp_log_pkg.sv
package fp_log_pkg;

	// apb byte addresses
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_OPWORD = 8'h04;
	localparam logic [7:0] ADDR_EA_DATA = 8'h08;
	localparam logic [7:0] ADDR_FPSR = 8'h0C;
	localparam logic [7:0] ADDR_STATUS = 8'h10;
	localparam logic [2:0] ADDR_FPREG_HI = 3'h1;

	// control register fields and reset values
	localparam int CTRL_ID_LSB = 0;
	localparam int CTRL_PACKED_INEX = 8;
	localparam logic [2:0] OWN_ID_RESET = 3'h1;

	// status register fields
	localparam int STAT_BUSY = 0;
	localparam int STAT_DONE = 1;
	localparam int STAT_REJECT_LSB = 4;

	// fpsr byte positions
	localparam int FPSR_QUOT_LSB = 16;
	localparam int FPSR_EXC_LSB = 8;
	localparam int FPSR_ACC_LSB = 0;

	// exception byte bits
	localparam int EXC_BRANCH_UNORDERED_FLAG = 7;
	localparam int EXC_SIGNALLING_NAN_FLAG = 6;
	localparam int EXC_OPERAND_ERROR_FLAG = 5;
	localparam int EXC_OVERFLOW_FLAG = 4;
	localparam int EXC_UNDERFLOW_FLAG = 3;
	localparam int EXC_DZ = 2;
	localparam int EXC_RESULT_INEXACT_FLAG = 1;
	localparam int EXC_DECIMAL_INPUT_INEXACT_FLAG = 0;

	// operation words
	localparam logic [3:0] LINE_HEADER = 4'hF;
	localparam logic [6:0] OPMODE_LOG2 = 7'h16;
	localparam logic [6:0] OPMODE_LN = 7'h14;

	typedef enum logic [2:0] {
		FMT_LONG, FMT_SINGLE, FMT_EXTENDED, FMT_PACKED,
		FMT_WORD, FMT_DOUBLE, FMT_BYTE, FMT_ILLEGAL
	} src_format_t;

	localparam logic [2:0] EA_DATA_DIRECT = 3'h0;
	localparam logic [2:0] EA_ADDR_DIRECT = 3'h1;
	localparam logic [2:0] EA_SPECIAL = 3'h7;
	localparam logic [2:0] EA_SPECIAL_MAX = 3'h4;

	typedef enum logic [2:0] {
		REJ_NONE, REJ_HEADER, REJ_NOT_OWN, REJ_COMMAND,
		REJ_OPMODE, REJ_FORMAT, REJ_EA
	} reject_t;

	// single precision constants
	localparam logic [31:0] POS_INF = 32'h7F800000;
	localparam logic [31:0] NEG_INF = 32'hFF800000;
	localparam logic [31:0] QUIET_NAN = 32'h7FC00000;
	localparam logic [31:0] QUIET_BIT = 32'h00400000;
	localparam logic [7:0] EXP_BIAS = 8'h7F;
	localparam logic [7:0] EXP_MAX = 8'hFF;
	localparam logic [7:0] FRAC_BIAS = 8'h68;
	localparam logic [15:0] LN2_Q16 = 16'hB172;

endpackage : fp_log_pkg

// file: test_fp_log_instruction_unit.sv
module test_fp_log_instruction_unit;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {logic [31:0] d; logic [31:0] m; logic e;} note_t;
	localparam logic [31:0] NAN_MASK = 32'h7FC00000;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, fm, seed, r, v, b;
	note_t nq[$];
	note_t nt;
	int n_fail = 0;
	int total_checks = 0;
	int cyc = 0;
	always #5 clk = ~clk;
	fp_log_instruction_unit dut (.clk(clk), .reset(reset), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));
	apb_host_model host (.clk(clk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));
	task check(input logic [32:0] s, input logic [32:0] e);
		total_checks++;
		if (s !== e) begin
			n_fail++;
			$display("MISMATCH %0t got %h expected %h", $time, s, e);
		end
	endtask : check
	task end_of_test;
		if (n_fail == 0 && total_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : end_of_test
	function logic [31:0] xs;
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	function logic [31:0] op(logic [2:0] id, logic rm, logic [2:0] s,
		logic [2:0] d, logic [5:0] ea, logic ln);
		// address field zero in register mode
		return {fp_log_pkg::LINE_HEADER, id, 3'h0, rm ? ea : 6'h00, 1'b0, rm,
			1'b0, s, d, ln ? fp_log_pkg::OPMODE_LN : fp_log_pkg::OPMODE_LOG2};
	endfunction : op
	task acc(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] m, input logic e);
		note_t n;
		logic x;
		n.d = d;
		n.m = m;
		n.e = e;
		nq.push_back(n);
		host.xfer(w, a, d, r, x);
	endtask : acc
	task run_op(input logic [31:0] ow, input logic [31:0] d,
		input logic [31:0] res, input logic [31:0] m, input logic [7:0] x,
		input logic [2:0] j);
		int k;
		k = 0;
		acc(1'b1, fp_log_pkg::ADDR_EA_DATA, d, 32'h0, 1'b0);
		acc(1'b1, fp_log_pkg::ADDR_OPWORD, ow, 32'h0, 1'b0);
		do begin
			acc(1'b0, fp_log_pkg::ADDR_STATUS, 32'h0, 32'h0, 1'b0);
			k++;
		end while (r[0] !== 1'b0 && k < 20);
		acc(1'b0, fp_log_pkg::ADDR_STATUS, {25'h0, j, 4'h2}, 32'h73, 1'b0);
		acc(1'b0, 8'h20 | {3'h0, ow[9:7], 2'h0}, res, m, 1'b0);
		if (j == 3'h0) begin
			fm = {fm[31:16], x, fm[7:0] | {x[7] | x[6] | x[5], x[4], x[3], x[2],
				x[1] | x[0] | x[4], 3'h0}};
		end
		acc(1'b0, fp_log_pkg::ADDR_FPSR, fm, 32'h00FFFFF8, 1'b0);
	endtask : run_op
	always @(posedge clk) begin
		if (psel && penable && pready === 1'b1 && nq.size() > 0) begin
			nt = nq.pop_front();
			check({prdata & nt.m, pslverr}, {nt.d & nt.m, nt.e});
		end
	end
	// several times the few hundred cycles the sequence needs
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			end_of_test();
		end
	end
	initial begin
		seed = 32'h00002BF2;
		repeat (12) @(posedge clk);
		reset <= 1'b0;
		acc(1'b0, fp_log_pkg::ADDR_CTRL, 32'h1, 32'hFFFFFFFF, 1'b0);
		acc(1'b0, fp_log_pkg::ADDR_STATUS, 32'h0, 32'hFFFFFFFF, 1'b0);
		acc(1'b0, 8'h40, 32'h0, 32'hFFFFFFFF, 1'b1);
		acc(1'b1, 8'h16, 32'h5, 32'h0, 1'b1);
		fm = 32'h005A9800;
		acc(1'b1, fp_log_pkg::ADDR_FPSR, fm, 32'h0, 1'b0);
		b = op(3'h1, 1'b1, 3'h1, 3'h0, 6'h3C, 1'b0);
		run_op(b, 32'h40000000, 32'h3F800000, '1, 8'h00, 3'h0);
		run_op(op(3'h1, 1'b1, 3'h1, 3'h1, 6'h03, 1'b1), 32'h3F800000, 32'h0,
			'1, 8'h00, 3'h0);
		run_op(op(3'h1, 1'b1, 3'h4, 3'h2, 6'h18, 1'b1), 32'h0000FFFB,
			NAN_MASK, NAN_MASK, 8'h20, 3'h0);
		run_op(op(3'h1, 1'b1, 3'h6, 3'h3, 6'h28, 1'b0), 32'h0,
			fp_log_pkg::NEG_INF, '1, 8'h04, 3'h0);
		run_op(op(3'h1, 1'b1, 3'h5, 3'h4, 6'h30, 1'b1), fp_log_pkg::POS_INF,
			fp_log_pkg::POS_INF, '1, 8'h00, 3'h0);
		run_op(op(3'h1, 1'b1, 3'h2, 3'h5, 6'h20, 1'b0), fp_log_pkg::NEG_INF,
			NAN_MASK, NAN_MASK, 8'h20, 3'h0);
		run_op(op(3'h1, 1'b1, 3'h0, 3'h6, 6'h3A, 1'b0), 32'h1, 32'h0, '1,
			8'h00, 3'h0);
		acc(1'b1, fp_log_pkg::ADDR_CTRL, 32'h101, 32'h0, 1'b0);
		run_op(op(3'h1, 1'b1, 3'h3, 3'h7, 6'h39, 1'b0), 32'h40000000,
			32'h3F800000, '1, 8'h01, 3'h0);
		run_op(op(3'h1, 1'b1, 3'h1, 3'h7, 6'h11, 1'b0), 32'h40000000,
			32'h3F800000, '1, 8'h00, 3'h0);
		for (int i = 0; i < 2; i++) begin
			v = xs();
			acc(1'b1, 8'h20 | {3'h0, v[31:29], 2'h0}, {3'h5, v[28:0]}, 32'h0,
				1'b0);
			run_op(op(3'h1, 1'b0, v[31:29], v[31:29] ^ 3'(i), 6'h3F, i[0]),
				32'h0, NAN_MASK, NAN_MASK, 8'h20, 3'h0);
		end
		// refused words must leave register 0 and the status word alone
		v = 32'h3F800000;
		acc(1'b1, 8'h20, v, 32'h0, 1'b0);
		run_op(op(3'h2, 1'b1, 3'h1, 3'h0, 6'h3C, 1'b0), v, v, '1, 8'h00,
			3'h2);
		run_op(b ^ 32'h10000000, v, v, '1, 8'h00, 3'h1);
		run_op(b ^ 32'h00002000, v, v, '1, 8'h00, 3'h3);
		run_op(b ^ 32'h00000001, v, v, '1, 8'h00, 3'h4);
		run_op(b ^ 32'h00001800, v, v, '1, 8'h00, 3'h5);
		run_op(b ^ 32'h00340000, v, v, '1, 8'h00, 3'h6);
		run_op(b ^ 32'h00010000, v, v, '1, 8'h00, 3'h6);
		run_op(op(3'h1, 1'b1, 3'h5, 3'h0, 6'h03, 1'b0), v, v, '1, 8'h00,
			3'h6);
		end_of_test();
	end
endmodule : test_fp_log_instruction_unit
bind fp_log_instruction_unit fp_log_checker chk (.clk(clk), .reset(reset),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
